//--- logic/ddrsd_map.svh
// Register offsets, field positions and reset values of the strobe block
`ifndef DDRSD_MAP_SVH
`define DDRSD_MAP_SVH

// Word offsets on the Wishbone bus (byte addresses)
`define DDRSD_ADR_CTRL        8'h00
`define DDRSD_ADR_STATUS      8'h04
`define DDRSD_ADR_EQ          8'h08
`define DDRSD_ADR_CAP_LO      8'h0c
`define DDRSD_ADR_CAP_HI      8'h10

// Control word fields
`define DDRSD_CTRL_X2_BIT     0
`define DDRSD_CTRL_STSEL_BIT  1
`define DDRSD_CTRL_STDLY_LSB  8
`define DDRSD_CTRL_STDLY_MSB  15
`define DDRSD_STDLY_RESET     8'h00

// Status word fields
`define DDRSD_ST_VALID_BIT    0
`define DDRSD_ST_PREAMB_BIT   1
`define DDRSD_ST_POL_BIT      2
`define DDRSD_ST_X2_BIT       3
`define DDRSD_ST_WDLY_LSB     8
`define DDRSD_ST_WDLY_MSB     15
`define DDRSD_ST_CODE_LSB     16
`define DDRSD_ST_CODE_MSB     22

// Delay line and write delay setting layout
`define DDRSD_TAPS            128
`define DDRSD_STEP_PS         25
`define DDRSD_INVERT_BIT      7
`define DDRSD_EQ_RESET        2'h0

`endif

//--- logic/ddrsd_pkg.sv
// Types shared by the strobe delay and control block
`default_nettype none
package ddrsd_pkg;
	// Seven-bit calibration code from a delay-locked loop
	typedef logic [6:0] ddrsd_code_t;
	// Eight-bit write delay setting: invert flag over a tap number
	typedef logic [7:0] ddrsd_wdelay_t;
	// Write gearing phase, Gray coded around the loop
	typedef enum logic [1:0] {
		DDRSD_GEAR_0 = 2'h0,
		DDRSD_GEAR_1 = 2'h1,
		DDRSD_GEAR_2 = 2'h3,
		DDRSD_GEAR_3 = 2'h2
	} ddrsd_gear_t;
endpackage : ddrsd_pkg
`default_nettype wire

//--- logic/ddr_strobe_delay_control.sv
// Strobe delay and control logic for one DDR strobe group
//
// Local design decisions: register access over Wishbone and the register addresses.
`default_nettype none
`include "ddrsd_map.svh"

module ddr_strobe_delay_control #(
	parameter int DQ_WIDTH    = 11,  // Data pads in the group
	parameter int BANK        = 0,   // Bank holding the strobe pin
	parameter bit BOTTOM_EDGE = 1'b0 // Group sits on the bottom edge
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	input  wire logic                    globalSetResetN,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [31:0]             wb_dat_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic                    wb_we_i,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	output logic [31:0]                  wb_dat_o,
	output logic                         wb_ack_o,
	input  wire logic                    rawStrobeIn,
	input  wire logic [DQ_WIDTH-1:0]     dqIn,
	input  wire ddrsd_pkg::ddrsd_code_t  leftDllCode,
	input  wire ddrsd_pkg::ddrsd_code_t  rightDllCode,
	input  wire logic                    readActive,
	input  wire logic                    writeActive,
	input  wire ddrsd_pkg::ddrsd_wdelay_t dynamicWriteDelay,
	output logic                         delayedReadStrobe,
	output logic                         syncClockPolarity,
	output logic                         gearboxTransferEnable,
	output logic                         writeGearClockA,
	output logic                         writeGearClockB,
	output logic                         strobeOut,
	output logic                         strobeOe,
	output logic                         captureValidFlag,
	output logic                         preambleDetect,
	output logic [2*DQ_WIDTH-1:0]        eqSetting
);

	localparam int W     = DQ_WIDTH;
	localparam int TAPS  = `DDRSD_TAPS;
	// Banks served by the left loop; banks 1 to 3 take the right loop
	localparam bit LEFT  = (BANK == 0) || (BANK == 7) || (BANK == 6);
	localparam bit RIGHT = (BANK == 1) || (BANK == 2) || (BANK == 3);

	// Refuse group sizes and banks that have no strobe delay path
	if (W != 10 && W != 11) begin : gWidthCheck
		$error("DQ_WIDTH must be 10 or 11");
	end
	if (!LEFT && !RIGHT) begin : gBankCheck
		$error("BANK has no strobe delay loop");
	end

	// Merges a bus write into an old word under the byte selects
	function automatic logic [31:0] busMerge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				res[8*i +: 8] = data[8*i +: 8];
			end
		end
		return res;
	endfunction : busMerge

	// Word decode of a bus address against a register offset
	function automatic logic hitAt(input logic [7:0] adr,
		input logic [7:0] off);
		return adr[7:2] == off[7:2];
	endfunction : hitAt

	// Synchronisers for pins from outside the clock domain
	logic [1:0]   gsrSync;              // Global reset, active low
	logic [1:0]   strobeSync;           // Raw strobe samples
	logic [W-1:0] dqMeta;               // Data first stage
	logic [W-1:0] dqSync;               // Data second stage
	logic         coreRst;              // Combined block reset

	// Two flip-flops each; only the second stage is read by logic
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			gsrSync    <= 2'h3;
			strobeSync <= 2'h0;
			dqMeta     <= '0;
			dqSync     <= '0;
		end else begin
			gsrSync    <= {gsrSync[0], globalSetResetN};
			strobeSync <= {strobeSync[0], rawStrobeIn};
			dqMeta     <= dqIn;
			dqSync     <= dqMeta;
		end
	end

	// Global set/reset acts like the block reset once synchronised
	assign coreRst = rst | ~gsrSync[1];

	// Pad bias pulls the idle strobe high, so a level high reads
	// as preamble while nobody drives the line
	assign preambleDetect = strobeSync[1];

	// Bus-visible configuration
	logic                     x2Mode, next_x2Mode;       // Gearbox x2
	logic                     staticSel, next_staticSel; // Use static
	ddrsd_pkg::ddrsd_wdelay_t staticDelay, next_staticDelay;
	logic [2*W-1:0]           next_eqSetting;           // Per pad eq
	logic                     next_ack;
	logic [31:0]              next_datOut;
	logic                     busHit;                   // New request
	logic                     capRead;                  // Clears valid
	logic [31:0]              ctrlWord, ctrlNew;
	logic [31:0]              statusWord;
	logic [31:0]              eqNew;

	// Read side state
	ddrsd_pkg::ddrsd_code_t   dllCode;                  // Selected code
	logic [TAPS-1:0]          rdLine, next_rdLine;      // Strobe taps
	logic                     next_delayed;
	logic                     delayedPrev;              // Edge finder
	logic [W-1:0]             riseReg, next_riseReg;    // First stage
	logic [W-1:0]             fallReg, next_fallReg;
	logic [4*W-1:0]           stage2, next_stage2;      // Second stage
	logic                     pairOdd, next_pairOdd;    // X2 pairing
	logic                     next_transfer;
	logic                     next_valid;
	logic                     next_polarity;
	logic                     readPrev;
	logic                     riseEdge, fallEdge, transfer;
	logic [2*W-1:0]           pair;

	// Write side state
	ddrsd_pkg::ddrsd_gear_t   gear, next_gear;          // Divider phase
	logic [TAPS-1:0]          wrLine, next_wrLine;      // Clock taps
	ddrsd_pkg::ddrsd_wdelay_t applied, next_applied;    // Live setting
	ddrsd_pkg::ddrsd_wdelay_t wanted;
	logic                     curOut, candOut;
	logic                     next_strobeOut, next_strobeOe;

	// Left or right loop code, fixed by the bank at build time
	assign dllCode = LEFT ? leftDllCode : rightDllCode;

	// Assemble the words software sees
	always_comb begin
		ctrlWord = '0;
		ctrlWord[`DDRSD_CTRL_X2_BIT]    = x2Mode;
		ctrlWord[`DDRSD_CTRL_STSEL_BIT] = staticSel;
		ctrlWord[`DDRSD_CTRL_STDLY_MSB:`DDRSD_CTRL_STDLY_LSB] = staticDelay;
		statusWord = '0;
		statusWord[`DDRSD_ST_VALID_BIT]  = captureValidFlag;
		statusWord[`DDRSD_ST_PREAMB_BIT] = preambleDetect;
		statusWord[`DDRSD_ST_POL_BIT]    = syncClockPolarity;
		statusWord[`DDRSD_ST_X2_BIT]     = x2Mode;
		statusWord[`DDRSD_ST_WDLY_MSB:`DDRSD_ST_WDLY_LSB] = applied;
		statusWord[`DDRSD_ST_CODE_MSB:`DDRSD_ST_CODE_LSB] = dllCode;
	end

	// Wishbone slave: one wait state, ack for exactly one cycle
	always_comb begin
		busHit           = wb_cyc_i & wb_stb_i & ~wb_ack_o;
		next_ack         = busHit;
		next_datOut      = wb_dat_o;
		next_x2Mode      = x2Mode;
		next_staticSel   = staticSel;
		next_staticDelay = staticDelay;
		next_eqSetting   = eqSetting;
		ctrlNew          = busMerge(ctrlWord, wb_dat_i, wb_sel_i);
		eqNew            = busMerge({{(32-2*W){1'b0}}, eqSetting},
			wb_dat_i, wb_sel_i);
		capRead          = busHit & ~wb_we_i
			& hitAt(wb_adr_i, `DDRSD_ADR_CAP_LO);
		if (busHit && wb_we_i) begin
			// Writes land only on writable words; others are dropped
			if (hitAt(wb_adr_i, `DDRSD_ADR_CTRL)) begin
				next_x2Mode    = ctrlNew[`DDRSD_CTRL_X2_BIT];
				next_staticSel = ctrlNew[`DDRSD_CTRL_STSEL_BIT];
				next_staticDelay =
					ctrlNew[`DDRSD_CTRL_STDLY_MSB:`DDRSD_CTRL_STDLY_LSB];
			end else if (hitAt(wb_adr_i, `DDRSD_ADR_EQ)) begin
				next_eqSetting = eqNew[2*W-1:0];
			end
			next_datOut = '0;
		end else if (busHit) begin
			// Reads; unmapped words answer zero
			if (hitAt(wb_adr_i, `DDRSD_ADR_CTRL)) begin
				next_datOut = ctrlWord;
			end else if (hitAt(wb_adr_i, `DDRSD_ADR_STATUS)) begin
				next_datOut = statusWord;
			end else if (hitAt(wb_adr_i, `DDRSD_ADR_EQ)) begin
				next_datOut = {{(32-2*W){1'b0}}, eqSetting};
			end else if (capRead) begin
				next_datOut = {{(32-2*W){1'b0}}, stage2[2*W-1:0]};
			end else if (hitAt(wb_adr_i, `DDRSD_ADR_CAP_HI)) begin
				next_datOut = {{(32-2*W){1'b0}}, stage2[4*W-1:2*W]};
			end else begin
				next_datOut = '0;
			end
		end
	end

	// Bus registers
	always_ff @(posedge sys_clk) begin
		if (coreRst) begin
			wb_ack_o    <= 1'b0;
			wb_dat_o    <= '0;
			x2Mode      <= 1'b0;
			staticSel   <= 1'b0;
			staticDelay <= `DDRSD_STDLY_RESET;
			eqSetting   <= {W{`DDRSD_EQ_RESET}};
		end else begin
			wb_ack_o    <= next_ack;
			wb_dat_o    <= next_datOut;
			x2Mode      <= next_x2Mode;
			staticSel   <= next_staticSel;
			staticDelay <= next_staticDelay;
			eqSetting   <= next_eqSetting;
		end
	end

	// Read side: tap delay of the strobe, capture and hand-over
	always_comb begin
		next_rdLine  = {rdLine[TAPS-2:0], strobeSync[1]};
		// Loop code counts taps for a quarter strobe period
		next_delayed = rdLine[dllCode];
		riseEdge     = delayedReadStrobe & ~delayedPrev;
		fallEdge     = ~delayedReadStrobe & delayedPrev;
		// Same delayed strobe edges sample every pad of the group
		next_riseReg = riseEdge ? dqSync : riseReg;
		if (BOTTOM_EDGE) begin
			// One plain input register, no double-rate pair
			next_fallReg = '0;
			pair         = {{W{1'b0}}, dqSync};
			transfer     = riseEdge;
		end else begin
			next_fallReg = fallEdge ? dqSync : fallReg;
			pair         = {dqSync, riseReg};
			// In x2 mode the second stage loads every other pair
			transfer     = fallEdge & (~x2Mode | pairOdd);
		end
		next_pairOdd  = (fallEdge && x2Mode) ? ~pairOdd : pairOdd;
		next_transfer = transfer;
		if (transfer) begin
			next_stage2 = x2Mode ? {stage2[2*W-1:0], pair}
				: {{(2*W){1'b0}}, pair};
		end else begin
			next_stage2 = stage2;
		end
		// Only data captured during a marked read counts as valid;
		// a new capture beats a clearing read in the same cycle
		next_valid = (transfer & readActive)
			| (captureValidFlag & ~capRead);
		// Polarity follows the strobe phase at the start of a read
		// so the sync registers sample away from strobe edges
		if (readActive && !readPrev) begin
			next_polarity = ~delayedReadStrobe;
		end else begin
			next_polarity = syncClockPolarity;
		end
	end

	// Read side registers
	always_ff @(posedge sys_clk) begin
		if (coreRst) begin
			rdLine                <= '0;
			delayedReadStrobe     <= 1'b0;
			delayedPrev           <= 1'b0;
			riseReg               <= '0;
			fallReg               <= '0;
			stage2                <= '0;
			pairOdd               <= 1'b0;
			gearboxTransferEnable <= 1'b0;
			captureValidFlag      <= 1'b0;
			syncClockPolarity     <= 1'b0;
			readPrev              <= 1'b0;
		end else begin
			rdLine                <= next_rdLine;
			delayedReadStrobe     <= next_delayed;
			delayedPrev           <= delayedReadStrobe;
			riseReg               <= next_riseReg;
			fallReg               <= next_fallReg;
			stage2                <= next_stage2;
			pairOdd               <= next_pairOdd;
			gearboxTransferEnable <= next_transfer;
			captureValidFlag      <= next_valid;
			syncClockPolarity     <= next_polarity;
			readPrev              <= readActive;
		end
	end

	// Write side: gearing divider, tap line and delay selection
	always_comb begin
		// Gray walk; clock B leads clock A by one quarter
		unique case (gear)
			ddrsd_pkg::DDRSD_GEAR_0: next_gear = ddrsd_pkg::DDRSD_GEAR_1;
			ddrsd_pkg::DDRSD_GEAR_1: next_gear = ddrsd_pkg::DDRSD_GEAR_2;
			ddrsd_pkg::DDRSD_GEAR_2: next_gear = ddrsd_pkg::DDRSD_GEAR_3;
			ddrsd_pkg::DDRSD_GEAR_3: next_gear = ddrsd_pkg::DDRSD_GEAR_0;
		endcase
		next_wrLine = {wrLine[TAPS-2:0], writeGearClockA};
		// Controller leveling value unless the static value is chosen
		wanted  = staticSel ? staticDelay
			: dynamicWriteDelay;
		// Tap from the low bits, optional inversion from the top bit
		curOut  = wrLine[applied[6:0]]
			^ applied[`DDRSD_INVERT_BIT];
		candOut = wrLine[wanted[6:0]] ^ wanted[`DDRSD_INVERT_BIT];
		// Switch only where old and new paths agree, so no runt
		// pulse reaches the pad; a setting whose output never agrees
		// with the current one is never applied
		if (wanted != applied && candOut == curOut) begin
			next_applied   = wanted;
			next_strobeOut = candOut;
		end else begin
			next_applied   = applied;
			next_strobeOut = curOut;
		end
		next_strobeOe = writeActive;
	end

	// Write side registers; gearing clocks come straight off flops
	always_ff @(posedge sys_clk) begin
		if (coreRst) begin
			gear            <= ddrsd_pkg::DDRSD_GEAR_0;
			writeGearClockA <= 1'b0;
			writeGearClockB <= 1'b0;
			wrLine          <= '0;
			applied         <= '0;
			strobeOut       <= 1'b0;
			strobeOe        <= 1'b0;
		end else begin
			gear            <= next_gear;
			writeGearClockA <= next_gear[1];
			writeGearClockB <= next_gear[0];
			wrLine          <= next_wrLine;
			applied         <= next_applied;
			// Shifted strobe feeds only the strobe pad drivers
			strobeOut       <= next_strobeOut;
			strobeOe        <= next_strobeOe;
		end
	end

endmodule : ddr_strobe_delay_control
`default_nettype wire

//--- testbench/ddrsd_assertions.sv
// Port-level checks for the strobe delay and control block
`default_nettype none
module ddrsd_chk #(
	parameter int DQ_WIDTH = 11 // Data pads in the group
) (
	input wire logic                  sys_clk,
	input wire logic                  rst,
	input wire logic [7:0]            wb_adr_i,
	input wire logic                  wb_we_i,
	input wire logic                  wb_cyc_i,
	input wire logic                  wb_stb_i,
	input wire logic                  wb_ack_o,
	input wire logic                  readActive,
	input wire logic                  writeActive,
	input wire logic                  gearboxTransferEnable,
	input wire logic                  writeGearClockA,
	input wire logic                  writeGearClockB,
	input wire logic                  strobeOe,
	input wire logic                  captureValidFlag,
	input wire logic [2*DQ_WIDTH-1:0] eqSetting
);
	// Read of the newest captured pair, which may clear the valid flag
	logic capRead;
	assign capRead = wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i[7:2] == 6'h03;

	ack_timing_a: assert property (@(posedge sys_clk) disable iff (rst)
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("Bus answer late or too long");
	gear_period_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(writeGearClockA) |-> ##4 $rose(writeGearClockA))
		else $error("Gear clock A period wrong");
	gear_phase_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(writeGearClockB) |=> $rose(writeGearClockA) ##1 $fell(writeGearClockB))
		else $error("Gear clocks not a quarter apart");
	oe_follow_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(writeActive) |=> $rose(strobeOe))
		else $error("Strobe enable missed write marker");
	xfer_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
		gearboxTransferEnable |=> !gearboxTransferEnable)
		else $error("Transfer enable longer than a cycle");
	valid_cause_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(captureValidFlag) |-> $past(readActive))
		else $error("Valid set outside a read");
	valid_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		captureValidFlag && !capRead && !$past(capRead) |=> captureValidFlag)
		else $error("Valid dropped without a read");
	eq_reset_a: assert property (@(posedge sys_clk)
		rst |=> eqSetting == '0 && !captureValidFlag && !wb_ack_o)
		else $error("Reset values wrong");
endmodule : ddrsd_chk
bind ddr_strobe_delay_control ddrsd_chk #(.DQ_WIDTH(DQ_WIDTH)) chk_u (
	.sys_clk(sys_clk), .rst(rst), .wb_adr_i(wb_adr_i), .wb_we_i(wb_we_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.readActive(readActive), .writeActive(writeActive),
	.gearboxTransferEnable(gearboxTransferEnable),
	.writeGearClockA(writeGearClockA), .writeGearClockB(writeGearClockB),
	.strobeOe(strobeOe), .captureValidFlag(captureValidFlag),
	.eqSetting(eqSetting));
`default_nettype wire

//--- testbench/ddrsd_mem_model.sv
// Memory device model answering reads with a strobe burst
`default_nettype none
module ddrsd_mem_model #(
	parameter int W = 11 // Data pads in the group
) (
	input  wire logic         go,
	input  wire logic [1:0]   pairs,
	input  wire logic [W-1:0] riseData,
	input  wire logic [W-1:0] fallData,
	output logic              strobe,
	output logic [W-1:0]      dq,
	output logic              busy
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle pad is biased high; released data shows the inverse of the last
	initial begin
		strobe = 1'b1;
		dq = '0;
		busy = 1'b0;
	end
	// Preamble low, then rise and fall beats at a 125 ns period; the odd
	// start offset keeps pad edges off the system clock edges
	always @(posedge go) begin
		busy = 1'b1;
		#3.3;
		strobe = 1'b0;
		dq = ~dq;
		#62.5;
		for (int i = 0; i < pairs; i++) begin
			strobe = 1'b1;
			dq = riseData + W'(i);
			#62.5;
			strobe = 1'b0;
			dq = fallData + W'(i);
			#62.5;
		end
		strobe = 1'b1;
		dq = ~dq;
		#62.5;
		busy = 1'b0;
	end
endmodule : ddrsd_mem_model
`default_nettype wire

//--- testbench/ddr_strobe_delay_control_tb_top.sv
// Self-checking bench for the strobe delay and control block
`default_nettype none
module ddr_strobe_delay_control_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [6:0] CODE = 7'h02; // Short, keeps capture in half period
	logic        sysClk = 1'b0, rst = 1'b1, we = 1'b0, cyc = 1'b0, stb = 1'b0;
	logic        readAct = 1'b0, writeAct = 1'b0, go = 1'b0;
	logic [7:0]  adr = '0, dynW = '0;
	logic [31:0] wdat = '0, rdat;
	logic [3:0]  sel = '0;
	logic [1:0]  pairs = '0;
	logic        ack, strobe, busy, dRd, pol, xfer, gearA, gearB, sOut, sOe;
	logic        valid, preamb, rawPrev = 1'b1, delPrev = 1'b1;
	logic [10:0] dq;
	logic [21:0] eq;
	int          mismatches = 0, cmpCount = 0, cycles = 0, pulses = 0;
	int          rawRise = 0, delRise = 0;

	ddr_strobe_delay_control dut_u (.sys_clk(sysClk), .rst(rst),
		.globalSetResetN(1'b1), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_dat_o(rdat), .wb_ack_o(ack), .rawStrobeIn(strobe), .dqIn(dq),
		.leftDllCode(CODE), .rightDllCode(7'h05), .readActive(readAct),
		.writeActive(writeAct), .dynamicWriteDelay(dynW),
		.delayedReadStrobe(dRd), .syncClockPolarity(pol),
		.gearboxTransferEnable(xfer), .writeGearClockA(gearA),
		.writeGearClockB(gearB), .strobeOut(sOut), .strobeOe(sOe),
		.captureValidFlag(valid), .preambleDetect(preamb), .eqSetting(eq));
	ddrsd_mem_model mem_u (.go(go), .pairs(pairs), .riseData(11'h155),
		.fallData(11'h2aa), .strobe(strobe), .dq(dq), .busy(busy));

	always #5 sysClk = ~sysClk;
	// Cycle count, hang limit, transfer pulses and strobe edge times
	always @(posedge sysClk) begin
		cycles++;
		if (xfer === 1'b1) pulses++;
		if (strobe === 1'b1 && rawPrev === 1'b0) rawRise = cycles;
		if (dRd === 1'b1 && delPrev === 1'b0) delRise = cycles;
		rawPrev = strobe;
		delPrev = dRd;
		if (cycles == 20000) begin
			mismatches++;
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] g, e);
		cmpCount++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Classic single Wishbone cycle; data taken at the edge that sees ack
	task automatic bus(input logic [7:0] a, input logic w,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
		int n;
		n = 0;
		adr <= a;
		we <= w;
		wdat <= d;
		sel <= s;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge sysClk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		chk(ack, 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge sysClk);
	endtask : bus
	// Poll status until the write delay setting has been applied
	task automatic applied(input logic [7:0] v);
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			bus(8'h04, 1'b0, '0, 4'hf, q);
			n++;
		end while (q[15:8] !== v && n < 40);
		chk(q[15:8], v);
	endtask : applied
	// Cycles from a gear clock A rise to the next write strobe rise, mod 4
	task automatic phase(input logic [7:0] v, output int d);
		logic s0;
		dynW <= v;
		applied(v);
		do @(negedge sysClk); while (gearA !== 1'b0);
		do @(negedge sysClk); while (gearA !== 1'b1);
		d = 0;
		do begin
			s0 = sOut;
			@(negedge sysClk);
			d++;
		end while (!(s0 === 1'b0 && sOut === 1'b1) && d < 9);
		d = d % 4;
		@(posedge sysClk);
	endtask : phase
	// Read burst from the memory model, marker raised late here or early by the caller
	task automatic burst(input logic [1:0] n, input logic late);
		pairs <= n;
		go <= 1'b1;
		repeat (8) @(posedge sysClk);
		go <= 1'b0;
		if (late) readAct <= 1'b1;
		while (busy === 1'b1) @(posedge sysClk);
		repeat (16) @(posedge sysClk);
		readAct <= 1'b0;
	endtask : burst

	task automatic t_regs();
		logic [31:0] q;
		chk(eq, '0);
		chk(preamb, 1'b1);
		bus(8'h04, 1'b0, '0, 4'hf, q);
		chk(q[22:16], CODE);
		bus(8'h14, 1'b0, '0, 4'hf, q);
		chk(q, '0);
		bus(8'h08, 1'b1, 32'hffffffff, 4'h1, q);
		chk(eq, 22'h0000ff);
		bus(8'h08, 1'b1, 32'h003aaaa5, 4'hf, q);
		bus(8'h08, 1'b0, '0, 4'hf, q);
		chk(q, 32'h003aaaa5);
		$display("Register test done");
	endtask : t_regs

	task automatic t_read(input logic x2);
		logic [31:0] q;
		int p0;
		bus(8'h00, 1'b1, {31'h0, x2}, 4'hf, q);
		p0 = pulses;
		readAct <= !x2;
		burst(x2 ? 2'd3 : 2'd1, x2);
		chk(pulses - p0, 2);
		chk(delRise - rawRise, 4 + CODE);
		bus(8'h04, 1'b0, '0, 4'hf, q);
		chk(q[3:0], {x2, x2, 2'b11});
		bus(8'h0c, 1'b0, '0, 4'hf, q);
		if (!x2) chk(q, {10'h0, 11'h2aa, 11'h155});
		bus(8'h04, 1'b0, '0, 4'hf, q);
		chk(q[0], 1'b0);
		burst(2'd1, 1'b0);
		bus(8'h04, 1'b0, '0, 4'hf, q);
		chk(q[0], 1'b0);
		$display("Read test done");
	endtask : t_read

	task automatic t_write();
		logic [31:0] q;
		int d1, d2, d81;
		writeAct <= 1'b1;
		// Steps chosen so old and new tap outputs can meet; a half
		// period jump would never be applied
		phase(8'h01, d1);
		phase(8'h02, d2);
		phase(8'h81, d81);
		chk((d2 - d1 + 4) % 4, 1);
		chk((d81 - d1 + 4) % 4, 2);
		chk(sOe, 1'b1);
		bus(8'h00, 1'b1, 32'h00004602, 4'hf, q);
		applied(8'h46);
		$display("Write test done");
	endtask : t_write

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", cmpCount, mismatches);
		if (mismatches == 0 && cmpCount > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (12) @(posedge sysClk);
		rst <= 1'b0;
		repeat (4) @(posedge sysClk);
		t_regs();
		t_read(1'b0);
		t_read(1'b1);
		t_write();
		end_of_test();
	end
endmodule : ddr_strobe_delay_control_tb_top
`default_nettype wire
